// ---- rtl/intc_consts.svh ----
// Register offsets, field positions, reset values and vector constants of the interrupt controller.
`ifndef INTC_CONSTS_SVH
`define INTC_CONSTS_SVH

// Register byte addresses on the register bus.
`define ADDR_EXT_INT_CTRL_FLAGS 8'h88
`define ADDR_INTERRUPT_ENABLES 8'ha8
`define ADDR_PRIORITY_LEVELS_A 8'hb8
`define ADDR_PRIORITY_LEVELS_B 8'hc0
`define ADDR_PRIORITY_LEVELS_C 8'hc8
`define ADDR_PRIORITY_LEVELS_D 8'hd8
`define ADDR_SOURCE_SELECT 8'he0
`define ADDR_SERIAL_FLAGS 8'he4
`define ADDR_SERVICE_STATUS 8'he8

// Fields of ext_int_ctrl_flags.
`define BIT_EXT_ONE_PENDING 7
`define BIT_OVERTEMP_STATE 6
`define BIT_OVERTEMP_PENDING 5
`define BIT_EXT_ZERO_PENDING 2

// Fields of interrupt_enables.
`define BIT_GLOBAL_IRQ_ENABLE 7
`define BIT_CLOCK_CALENDAR_IRQ_ENABLE 6
`define BIT_SERIAL_PORT_IRQ_ENABLE 4
`define BIT_EXT_ONE_IRQ_ENABLE 2
`define BIT_OVERTEMP_IRQ_ENABLE 1
`define BIT_EXT_ZERO_IRQ_ENABLE 0
`define ENABLES_WRITE_MASK 8'hd7

// Priority storage: four 8-bit registers, the top two bits of the last are reserved.
`define PRIO_LAST_MASK 8'h3f
`define PRIO_RESET 32'h0000_0000

// Source count and fixed-order indices of sources with special enables.
`define NUM_SOURCES 15
`define IDX_LOWVOLT_OVERTEMP 0
`define IDX_EXT_ZERO 1
`define IDX_EXT_ONE 2
`define IDX_CLOCK_CALENDAR 8
`define IDX_SERIAL 14
`define NUM_PERIPH 11
`define FIRST_PERIPH 3

// Vector addresses.
`define RESET_VECTOR 16'h0000
`define VECTOR_BASE 16'h0003
`define VECTOR_LAST 16'h0073

// Bus reset values.
`define READDATA_RESET 8'h00

`endif

// ---- rtl/intc_pkg.sv ----
// Types shared by the interrupt controller and its surroundings.
package intc_pkg;

    // Avalon-MM request from the bus master.
    typedef struct packed {
        logic read;
        logic write;
        logic [7:0] address;
        logic [31:0] writedata;
        logic [3:0] byteenable;
    } avmm_req_t;

    // Avalon-MM answer to the bus master.
    typedef struct packed {
        logic waitrequest;
        logic [31:0] readdata;
    } avmm_rsp_t;

    // Vectored request towards the processor core.
    typedef struct packed {
        logic req;
        logic [1:0] level;
        logic [15:0] vector;
    } core_irq_t;

    // Whole state of the controller.
    typedef struct packed {
        logic [7:0] pin_s1;
        logic [7:0] pin_s2;
        logic ot_s1;
        logic ot_s2;
        logic ot_prev;
        logic line0_prev;
        logic line1_prev;
        logic ext_zero_pending;
        logic ext_one_pending;
        logic overtemp_pending;
        logic [1:0] ext_zero_trigger_sel;
        logic [1:0] ext_one_trigger_sel;
        logic [7:0] enables;
        logic [31:0] prio;
        logic [7:0] source_sel;
        logic serial_rx_done_flag;
        logic serial_tx_done_flag;
        logic [3:0] in_service;
        logic irq_req;
        logic [1:0] irq_level;
        logic [15:0] irq_vector;
        logic waitrequest;
        logic [7:0] readdata;
    } intc_state_t;

endpackage : intc_pkg

// ---- rtl/prioritized_interrupt_controller.sv ----
// Prioritized vectored interrupt controller with two external lines and an Avalon-MM register port.
//
// Implementation choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`include "intc_consts.svh"

module prioritized_interrupt_controller
    import intc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire avmm_req_t avmm_req,
    output avmm_rsp_t avmm_rsp,
    input wire logic [7:0] ext_pins,
    input wire logic overtemp_above,
    input wire logic low_voltage_warning,
    input wire logic [10:0] periph_req,
    input wire logic serial_rx_set,
    input wire logic serial_tx_set,
    input wire logic irq_ack,
    input wire logic irq_return,
    output core_irq_t core_irq
);

    // Registered state and its next value.
    intc_state_t st_r;
    intc_state_t st_nxt;

    // Raw request of every source before the global gate.
    logic [14:0] src_req;
    // Selected external lines after synchronisation.
    logic line0;
    logic line1;
    // Edge events that set the pending flags.
    logic ev_zero;
    logic ev_one;
    logic ot_rise;
    // Bus write and read accepted in this cycle.
    logic wr_en;
    logic rd_en;
    logic [7:0] wd;
    // Arbitration result.
    logic found;
    logic [3:0] best_idx;
    logic [1:0] best_lvl;
    logic run_any;
    logic [1:0] run_lvl;

    // Outputs come straight from the state flip-flops.
    assign avmm_rsp.waitrequest = st_r.waitrequest;
    assign avmm_rsp.readdata = {24'h00_0000, st_r.readdata};
    assign core_irq.req = st_r.irq_req;
    assign core_irq.level = st_r.irq_level;
    assign core_irq.vector = st_r.irq_vector;

    // Edge detector for one external line.
    function automatic logic trig_event(input logic [1:0] sel, input logic cur, input logic prev);
        logic ev;
        ev = 1'b0;
        if (sel[1]) begin
            ev = cur ^ prev;
        end else if (sel[0]) begin
            ev = prev & ~cur;
        end else begin
            ev = cur & ~prev;
        end
        return ev;
    endfunction : trig_event

    // Pin selection and event detection on synchronised samples.
    assign line0 = st_r.pin_s2[st_r.source_sel[2:0]];
    assign line1 = st_r.pin_s2[st_r.source_sel[6:4]];
    assign ev_zero = trig_event(st_r.ext_zero_trigger_sel, line0, st_r.line0_prev);
    assign ev_one = trig_event(st_r.ext_one_trigger_sel, line1, st_r.line1_prev);
    assign ot_rise = st_r.ot_s2 & ~st_r.ot_prev;

    // A write takes effect on the edge where waitrequest is seen low; a read is sampled on the edge before, in the wait cycle.
    assign wr_en = avmm_req.write & ~st_r.waitrequest & avmm_req.byteenable[0];
    assign rd_en = avmm_req.read & st_r.waitrequest;
    assign wd = avmm_req.writedata[7:0];

    // Per-source request: flag and enable of each source; the low-voltage warning has no enable.
    assign src_req[`IDX_LOWVOLT_OVERTEMP] = low_voltage_warning
        | (st_r.overtemp_pending & st_r.enables[`BIT_OVERTEMP_IRQ_ENABLE]);
    assign src_req[`IDX_EXT_ZERO] = st_r.ext_zero_pending
        & st_r.enables[`BIT_EXT_ZERO_IRQ_ENABLE];
    assign src_req[`IDX_EXT_ONE] = st_r.ext_one_pending
        & st_r.enables[`BIT_EXT_ONE_IRQ_ENABLE];
    assign src_req[`IDX_SERIAL] = (st_r.serial_rx_done_flag | st_r.serial_tx_done_flag)
        & st_r.enables[`BIT_SERIAL_PORT_IRQ_ENABLE];

    // Peripheral sources arrive already gated by their own flag and enable, except the clock-calendar source, whose enable is applied here.
    for (genvar g = 0; g < `NUM_PERIPH; g++) begin : g_periph
        if (g + `FIRST_PERIPH == `IDX_CLOCK_CALENDAR) begin : g_rtc
            assign src_req[g + `FIRST_PERIPH] = periph_req[g]
                & st_r.enables[`BIT_CLOCK_CALENDAR_IRQ_ENABLE];
        end else begin : g_plain
            assign src_req[g + `FIRST_PERIPH] = periph_req[g];
        end
    end

    // Next-state logic for synchronisers, registers, flags, service tracking and bus.
    always_comb begin
        st_nxt = st_r;
        found = 1'b0;
        best_idx = 4'h0;
        best_lvl = 2'b00;
        run_any = 1'b0;
        run_lvl = 2'b00;

        // Two-stage synchronisers; only the second stage is read.
        st_nxt.pin_s1 = ext_pins;
        st_nxt.pin_s2 = st_r.pin_s1;
        st_nxt.ot_s1 = overtemp_above;
        st_nxt.ot_s2 = st_r.ot_s1;
        st_nxt.ot_prev = st_r.ot_s2;
        st_nxt.line0_prev = line0;
        st_nxt.line1_prev = line1;

        // Register writes; pending flags only clear on a written zero, serial flags take the written value.
        if (wr_en) begin
            if (avmm_req.address == `ADDR_EXT_INT_CTRL_FLAGS) begin
                if (!wd[`BIT_EXT_ONE_PENDING]) begin
                    st_nxt.ext_one_pending = 1'b0;
                end
                if (!wd[`BIT_OVERTEMP_PENDING]) begin
                    st_nxt.overtemp_pending = 1'b0;
                end
                if (!wd[`BIT_EXT_ZERO_PENDING]) begin
                    st_nxt.ext_zero_pending = 1'b0;
                end
                st_nxt.ext_one_trigger_sel = wd[4:3];
                st_nxt.ext_zero_trigger_sel = wd[1:0];
            end else if (avmm_req.address == `ADDR_INTERRUPT_ENABLES) begin
                st_nxt.enables = wd & `ENABLES_WRITE_MASK;
            end else if (avmm_req.address == `ADDR_PRIORITY_LEVELS_A) begin
                st_nxt.prio[7:0] = wd;
            end else if (avmm_req.address == `ADDR_PRIORITY_LEVELS_B) begin
                st_nxt.prio[15:8] = wd;
            end else if (avmm_req.address == `ADDR_PRIORITY_LEVELS_C) begin
                st_nxt.prio[23:16] = wd;
            end else if (avmm_req.address == `ADDR_PRIORITY_LEVELS_D) begin
                st_nxt.prio[31:24] = wd & `PRIO_LAST_MASK;
            end else if (avmm_req.address == `ADDR_SOURCE_SELECT) begin
                st_nxt.source_sel = wd & 8'h77;
            end else if (avmm_req.address == `ADDR_SERIAL_FLAGS) begin
                st_nxt.serial_rx_done_flag = wd[0];
                st_nxt.serial_tx_done_flag = wd[1];
            end
        end

        // Hardware events set flags after the write, so a set wins over a clear.
        if (ev_zero) begin
            st_nxt.ext_zero_pending = 1'b1;
        end
        if (ev_one) begin
            st_nxt.ext_one_pending = 1'b1;
        end
        if (ot_rise) begin
            st_nxt.overtemp_pending = 1'b1;
        end
        if (serial_rx_set) begin
            st_nxt.serial_rx_done_flag = 1'b1;
        end
        if (serial_tx_set) begin
            st_nxt.serial_tx_done_flag = 1'b1;
        end

        // Return from a routine releases the highest in-service level first.
        if (irq_return) begin
            if (st_r.in_service[3]) begin
                st_nxt.in_service[3] = 1'b0;
            end else if (st_r.in_service[2]) begin
                st_nxt.in_service[2] = 1'b0;
            end else if (st_r.in_service[1]) begin
                st_nxt.in_service[1] = 1'b0;
            end else begin
                st_nxt.in_service[0] = 1'b0;
            end
        end
        // Taking a vector marks its level as in service.
        if (irq_ack && st_r.irq_req) begin
            st_nxt.in_service[st_r.irq_level] = 1'b1;
        end

        // Highest level wins; scanning upward keeps the lowest index on ties.
        for (int i = 0; i < `NUM_SOURCES; i++) begin
            if (src_req[i]
                && (!found || st_r.prio[2*i +: 2] > best_lvl)) begin
                found = 1'b1;
                best_idx = 4'(i);
                best_lvl = st_r.prio[2*i +: 2];
            end
        end

        // Level of the routine now running, after this cycle's ack and return.
        for (int l = 0; l < 4; l++) begin
            if (st_nxt.in_service[l]) begin
                run_any = 1'b1;
                run_lvl = 2'(l);
            end
        end

        // Present only a strictly more urgent request, and nothing while globally disabled.
        st_nxt.irq_req = st_r.enables[`BIT_GLOBAL_IRQ_ENABLE] & found
            & (!run_any || best_lvl > run_lvl);
        if (found) begin
            st_nxt.irq_level = best_lvl;
            st_nxt.irq_vector = `VECTOR_BASE + {9'h000, best_idx, 3'b000};
        end

        // Bus answer: one wait cycle, then waitrequest low for one cycle.
        st_nxt.waitrequest = ~((avmm_req.read | avmm_req.write) & st_r.waitrequest);
        if (rd_en) begin
            if (avmm_req.address == `ADDR_EXT_INT_CTRL_FLAGS) begin
                st_nxt.readdata = {st_r.ext_one_pending, st_r.ot_s2, st_r.overtemp_pending,
                    st_r.ext_one_trigger_sel, st_r.ext_zero_pending,
                    st_r.ext_zero_trigger_sel};
            end else if (avmm_req.address == `ADDR_INTERRUPT_ENABLES) begin
                st_nxt.readdata = st_r.enables;
            end else if (avmm_req.address == `ADDR_PRIORITY_LEVELS_A) begin
                st_nxt.readdata = st_r.prio[7:0];
            end else if (avmm_req.address == `ADDR_PRIORITY_LEVELS_B) begin
                st_nxt.readdata = st_r.prio[15:8];
            end else if (avmm_req.address == `ADDR_PRIORITY_LEVELS_C) begin
                st_nxt.readdata = st_r.prio[23:16];
            end else if (avmm_req.address == `ADDR_PRIORITY_LEVELS_D) begin
                st_nxt.readdata = st_r.prio[31:24];
            end else if (avmm_req.address == `ADDR_SOURCE_SELECT) begin
                st_nxt.readdata = st_r.source_sel;
            end else if (avmm_req.address == `ADDR_SERIAL_FLAGS) begin
                st_nxt.readdata = {6'h00, st_r.serial_tx_done_flag, st_r.serial_rx_done_flag};
            end else if (avmm_req.address == `ADDR_SERVICE_STATUS) begin
                st_nxt.readdata = {st_r.irq_req, 1'b0, st_r.irq_level, st_r.in_service};
            end else begin
                st_nxt.readdata = `READDATA_RESET;
            end
        end
    end

    // State register; reset clears everything but waitrequest, which it sets, and parks the vector at the reset entry.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_r <= '0;
            st_r.prio <= `PRIO_RESET;
            st_r.irq_vector <= `RESET_VECTOR;
            st_r.waitrequest <= 1'b1;
            st_r.readdata <= `READDATA_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Checks of the controller's own behaviour.
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);

    // In-service bits at or above the presented level, for the preemption check.
    logic [3:0] svc_at_or_above;
    assign svc_at_or_above = st_r.in_service >> st_r.irq_level;

    a_global_gate_off: assert property (
        !st_r.enables[`BIT_GLOBAL_IRQ_ENABLE] |=> !st_r.irq_req)
        else $error("request presented while global enable is off");

    a_request_has_cause: assert property (
        st_r.irq_req |-> $past(st_r.enables[`BIT_GLOBAL_IRQ_ENABLE]) && $past(|src_req))
        else $error("request presented without enabled pending source");

    a_no_equal_preempt: assert property (st_r.irq_req |-> svc_at_or_above == 4'h0)
        else $error("request not above the running service level");

    a_vector_in_table: assert property (st_r.irq_req |-> st_r.irq_vector[2:0] == 3'b011
        && st_r.irq_vector <= `VECTOR_LAST)
        else $error("vector outside the table");

    a_zero_write_clears: assert property (
        wr_en && avmm_req.address == `ADDR_EXT_INT_CTRL_FLAGS
        && !wd[`BIT_EXT_ONE_PENDING] && !ev_one |=> !st_r.ext_one_pending)
        else $error("written zero did not clear line one flag");

    a_one_write_no_set: assert property (
        wr_en && avmm_req.address == `ADDR_EXT_INT_CTRL_FLAGS && wd[`BIT_EXT_ZERO_PENDING]
        && !st_r.ext_zero_pending && !ev_zero |=> !st_r.ext_zero_pending)
        else $error("software set a clear-only flag");

    a_serial_sw_set: assert property (
        wr_en && avmm_req.address == `ADDR_SERIAL_FLAGS && wd[0]
        |=> st_r.serial_rx_done_flag)
        else $error("software could not set the serial receive flag");

    a_overtemp_sets: assert property (ot_rise |=> st_r.overtemp_pending)
        else $error("overtemp event did not set pending flag");

    a_ack_marks_level: assert property (irq_ack && st_r.irq_req && !irq_return
        |=> st_r.in_service[$past(st_r.irq_level)])
        else $error("acknowledged level not marked in service");

    a_pending_held: assert property (st_r.ext_zero_pending && !st_r.enables[0]
        && !(wr_en && avmm_req.address == `ADDR_EXT_INT_CTRL_FLAGS)
        |=> st_r.ext_zero_pending)
        else $error("pending flag lost while disabled");

    a_bus_answers: assert property ((avmm_req.read || avmm_req.write) && st_r.waitrequest
        |=> !st_r.waitrequest ##1 st_r.waitrequest)
        else $error("bus answer not one cycle after request");

    c_preempt: cover property (irq_ack && st_r.irq_req && |st_r.in_service);
    c_serial_request: cover property (st_r.irq_req && st_r.irq_vector == `VECTOR_LAST);
    c_ext_edge: cover property (ev_one ##1 st_r.ext_one_pending);
    c_return: cover property (irq_return && |st_r.in_service);

endmodule : prioritized_interrupt_controller

// ---- testbench/core_model.sv ----
// Processor core model that takes interrupt vectors and returns from service routines.
`timescale 1ns/1ns

module core_model
    import intc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire core_irq_t core_irq,
    input wire logic ack_en,
    input wire logic [3:0] ack_delay,
    input wire logic ret_cmd,
    output logic irq_ack,
    output logic irq_return
);
    logic [3:0] wait_r; // Cycles the standing request has waited so far.

    // Takes a standing request after the chosen delay, so both prompt and slow cores occur.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            wait_r <= 4'h0;
            irq_ack <= 1'b0;
            irq_return <= 1'b0;
        end else begin
            irq_return <= ret_cmd;
            if (irq_ack || !core_irq.req) begin
                irq_ack <= 1'b0;
                wait_r <= 4'h0;
            end else if (ack_en && wait_r >= ack_delay) begin
                irq_ack <= 1'b1;
            end else begin
                wait_r <= wait_r + 4'h1;
            end
        end
    end
endmodule : core_model

// ---- testbench/prioritized_interrupt_controller_tb_top.sv ----
// Self-checking bench that compares the interrupt controller with a behavioural model.
`timescale 1ns/1ns
`include "intc_consts.svh"

module prioritized_interrupt_controller_tb_top
    import intc_pkg::*;
;
    logic sys_clk = 1'b0; // System clock, 40 ns period.
    logic rst_b; // Active-low reset.
    avmm_req_t req; // Register bus request.
    avmm_rsp_t rsp; // Register bus answer.
    logic [7:0] ext_pins;
    logic overtemp_above, low_voltage_warning, serial_rx_set, serial_tx_set;
    logic [10:0] periph_req;
    logic irq_ack, irq_return, ack_en, ret_cmd;
    logic [3:0] ack_delay;
    core_irq_t core_irq;
    int fail_count, n_checks, cycles;
    logic [31:0] seed, rd, prio_m; // Random state, read data, model of the levels.
    logic [7:0] en;
    logic [14:0] act;
    logic [10:0] pq;
    logic lq, rise, fall;
    logic [2:0] s0, s1;
    logic [1:0] tg;
    logic [7:0] pa [4] = '{`ADDR_PRIORITY_LEVELS_A, `ADDR_PRIORITY_LEVELS_B,
                           `ADDR_PRIORITY_LEVELS_C, `ADDR_PRIORITY_LEVELS_D};
    logic [7:0] ra [7] = '{`ADDR_EXT_INT_CTRL_FLAGS, `ADDR_INTERRUPT_ENABLES,
                           `ADDR_PRIORITY_LEVELS_A, `ADDR_PRIORITY_LEVELS_B,
                           `ADDR_PRIORITY_LEVELS_C, `ADDR_PRIORITY_LEVELS_D, 8'h90};

    prioritized_interrupt_controller dut (.sys_clk(sys_clk), .rst_b(rst_b), .avmm_req(req),
        .avmm_rsp(rsp), .ext_pins(ext_pins), .overtemp_above(overtemp_above),
        .low_voltage_warning(low_voltage_warning), .periph_req(periph_req),
        .serial_rx_set(serial_rx_set), .serial_tx_set(serial_tx_set), .irq_ack(irq_ack),
        .irq_return(irq_return), .core_irq(core_irq));
    core_model core (.sys_clk(sys_clk), .rst_b(rst_b), .core_irq(core_irq), .ack_en(ack_en),
        .ack_delay(ack_delay), .ret_cmd(ret_cmd), .irq_ack(irq_ack), .irq_return(irq_return));

    // Clock generator.
    always #20 sys_clk = ~sys_clk;

    // Cuts a hung run short.
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            fail_count++;
            end_of_test;
        end
    end

    // Xorshift step for reproducible random values.
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xs

    // Model arbitration: highest level wins, ties go to the lowest index, -1 when idle.
    function automatic int winner(input logic [14:0] a, input logic [31:0] pr);
        int w;
        w = -1;
        for (int i = 0; i < 15; i++) begin
            if (a[i] && (w < 0 || pr[2*i +: 2] > pr[2*w +: 2])) w = i;
        end
        return w;
    endfunction : winner

    // Prints the verdict and stops.
    task automatic end_of_test;
        if (fail_count == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_of_test

    // Counts a comparison and reports a mismatch.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wt(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : wt

    // One Avalon access; the request stands until the rising edge that sees waitrequest low.
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
                       output logic [31:0] q);
        @(posedge sys_clk);
        req <= '{read: !w, write: w, address: a, writedata: {24'h00_0000, d}, byteenable: 4'h1};
        @(posedge sys_clk);
        while (rsp.waitrequest !== 1'b0) begin
            @(posedge sys_clk);
        end
        // Read data is taken at the same edge that completes the transfer.
        q = rsp.readdata;
        req <= '0;
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, a, d, rd);
    endtask : wr

    task automatic rdchk(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
        bus(1'b0, a, 8'h00, rd);
        check(rd & {24'h00_0000, m}, {24'h00_0000, e & m});
    endtask : rdchk

    // Writes one priority register and keeps the model in step.
    task automatic setp(input int i, input logic [7:0] d);
        prio_m[8*i +: 8] = (i == 3) ? (d & `PRIO_LAST_MASK) : d;
        wr(pa[i], d);
    endtask : setp

    // Compares the core request with the model once the change has settled.
    task automatic core_chk(input int idx, input logic [31:0] pr);
        wt(3);
        @(negedge sys_clk);
        check({31'h0, core_irq.req}, {31'h0, idx >= 0});
        if (idx >= 0) begin
            check({16'h0000, core_irq.vector}, 32'h0000_0003 + 32'(8 * idx));
            check({30'h0, core_irq.level}, {30'h0, pr[2*idx +: 2]});
        end
        @(posedge sys_clk);
    endtask : core_chk

    task automatic ret_pulse;
        @(posedge sys_clk);
        ret_cmd <= 1'b1;
        @(posedge sys_clk);
        ret_cmd <= 1'b0;
    endtask : ret_pulse

    // Main sequence.
    initial begin
        req = '0;
        ext_pins = 8'h00;
        {overtemp_above, low_voltage_warning, serial_rx_set, serial_tx_set} = 4'h0;
        periph_req = 11'h000;
        {ack_en, ret_cmd, rst_b} = 3'h0;
        ack_delay = 4'h0;
        prio_m = `PRIO_RESET;
        seed = 32'h40cd_4ad5;
        wt(3);
        rst_b <= 1'b1;
        @(negedge sys_clk);
        check({16'h0000, core_irq.vector}, {16'h0000, `RESET_VECTOR});
        foreach (ra[i]) rdchk(ra[i], 8'h00, 8'hff);
        wr(8'h90, 8'hff);
        rdchk(8'h90, 8'h00, 8'hff);
        wr(`ADDR_INTERRUPT_ENABLES, 8'hff);
        rdchk(`ADDR_INTERRUPT_ENABLES, `ENABLES_WRITE_MASK, 8'hff);
        // Random levels, enables and requests against the arbitration model.
        for (int k = 0; k < 24; k++) begin
            for (int i = 0; i < 4; i++) begin
                seed = xs(seed);
                setp(i, seed[7:0]);
                rdchk(pa[i], prio_m[8*i +: 8], 8'hff);
            end
            seed = xs(seed);
            en = {seed[31:30], 6'h00};
            wr(`ADDR_INTERRUPT_ENABLES, en);
            pq = seed[10:0];
            lq = seed[11];
            periph_req <= pq;
            low_voltage_warning <= lq;
            act = {1'b0, pq, 2'h0, lq};
            act[8] = act[8] & en[6];
            if (!en[7]) act = '0;
            core_chk(winner(act, prio_m), prio_m);
        end
        // Nesting: equal level waits, higher level preempts, returns release levels.
        periph_req <= 11'h000;
        low_voltage_warning <= 1'b0;
        setp(0, 8'h40);
        setp(1, 8'h09);
        setp(2, 8'h00);
        setp(3, 8'h00);
        wr(`ADDR_INTERRUPT_ENABLES, 8'h80);
        ack_delay <= {2'h0, seed[1:0]};
        ack_en <= 1'b1;
        periph_req <= 11'h003;
        wt(12);
        core_chk(-1, prio_m);
        rdchk(`ADDR_SERVICE_STATUS, 8'h02, 8'h0f);
        ack_en <= 1'b0;
        periph_req <= 11'h007;
        core_chk(5, prio_m);
        ack_en <= 1'b1;
        wt(12);
        rdchk(`ADDR_SERVICE_STATUS, 8'h06, 8'h0f);
        ack_en <= 1'b0;
        periph_req <= 11'h003;
        ret_pulse;
        core_chk(-1, prio_m);
        ret_pulse;
        core_chk(3, prio_m);
        periph_req <= 11'h000;
        // External lines: every trigger mode on randomly selected pins.
        for (int m = 0; m < 3; m++) begin
            seed = xs(seed);
            s0 = seed[2:0];
            s1 = s0 + {1'b0, seed[4:3]} + 3'h1;
            tg = m[1:0];
            rise = (m != 1);
            fall = (m != 0);
            wr(`ADDR_SOURCE_SELECT, {1'b0, s1, 1'b0, s0});
            rdchk(`ADDR_SOURCE_SELECT, {1'b0, s1, 1'b0, s0}, 8'hff);
            wr(`ADDR_EXT_INT_CTRL_FLAGS, {3'h0, tg, 1'b0, tg});
            wt(5);
            wr(`ADDR_EXT_INT_CTRL_FLAGS, {3'h0, tg, 1'b0, tg});
            wr(`ADDR_INTERRUPT_ENABLES, 8'h85);
            ext_pins <= (8'h01 << s0) | (8'h01 << s1);
            wt(5);
            rdchk(`ADDR_EXT_INT_CTRL_FLAGS, {rise, 2'h0, tg, rise, tg}, 8'hff);
            core_chk(rise ? 1 : -1, prio_m);
            wr(`ADDR_INTERRUPT_ENABLES, 8'h00);
            wr(`ADDR_EXT_INT_CTRL_FLAGS, {3'h0, tg, 1'b0, tg});
            ext_pins <= 8'h00;
            wt(5);
            rdchk(`ADDR_EXT_INT_CTRL_FLAGS, {fall, 2'h0, tg, fall, tg}, 8'hff);
            wr(`ADDR_EXT_INT_CTRL_FLAGS, {3'h4, tg, 1'b0, tg});
            rdchk(`ADDR_EXT_INT_CTRL_FLAGS, {fall, 2'h0, tg, 1'b0, tg}, 8'hff);
            wr(`ADDR_EXT_INT_CTRL_FLAGS, {3'h0, tg, 1'b0, tg});
        end
        // Over-temperature flag held pending, then served, cleared and never set by software.
        wr(`ADDR_INTERRUPT_ENABLES, 8'h80);
        overtemp_above <= 1'b1;
        wt(5);
        rdchk(`ADDR_EXT_INT_CTRL_FLAGS, 8'h72, 8'hff);
        core_chk(-1, prio_m);
        wr(`ADDR_INTERRUPT_ENABLES, 8'h82);
        core_chk(0, prio_m);
        overtemp_above <= 1'b0;
        wr(`ADDR_EXT_INT_CTRL_FLAGS, 8'h12);
        core_chk(-1, prio_m);
        wr(`ADDR_EXT_INT_CTRL_FLAGS, 8'hb6);
        rdchk(`ADDR_EXT_INT_CTRL_FLAGS, 8'h12, 8'hff);
        // Serial flags set by software and by hardware pulses.
        wr(`ADDR_INTERRUPT_ENABLES, 8'h90);
        wr(`ADDR_SERIAL_FLAGS, 8'h03);
        rdchk(`ADDR_SERIAL_FLAGS, 8'h03, 8'hff);
        core_chk(14, prio_m);
        wr(`ADDR_SERIAL_FLAGS, 8'h00);
        rdchk(`ADDR_SERIAL_FLAGS, 8'h00, 8'hff);
        serial_rx_set <= 1'b1;
        serial_tx_set <= 1'b1;
        @(posedge sys_clk);
        serial_rx_set <= 1'b0;
        serial_tx_set <= 1'b0;
        rdchk(`ADDR_SERIAL_FLAGS, 8'h03, 8'hff);
        end_of_test;
    end
endmodule : prioritized_interrupt_controller_tb_top
